/* logic/sse_divider.sv */
// sequential signed-by-unsigned divider for the segment average
`timescale 1ns/1ps
module sse_divider
    import sse_pkg::*;
#(
    parameter int DW = SSE_SUM_W,
    parameter int VW = SSE_LEN_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic signed [DW-1:0] dividend,
    input wire logic [VW-1:0] divisor,
    output logic busy,
    output logic done,
    output logic signed [SSE_WORD_W-1:0] quotient
);
    logic [DW-1:0] dq_reg, dq_next;
    logic [VW:0] rem_reg, rem_next;
    logic [VW-1:0] div_reg, div_next;
    logic neg_reg, neg_next;
    logic [7:0] cnt_reg, cnt_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic signed [SSE_WORD_W-1:0] q_reg, q_next;

    always_comb begin
        logic [VW+1:0] shifted;
        logic [DW-1:0] qd;
        shifted = '0;
        qd = '0;
        dq_next = dq_reg;
        rem_next = rem_reg;
        div_next = div_reg;
        neg_next = neg_reg;
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        q_next = q_reg;
        if (start && !busy_reg) begin
            // work on the magnitude, fix the sign at the end
            dq_next = dividend[DW-1] ? DW'(-dividend) : dividend;
            neg_next = dividend[DW-1];
            rem_next = '0;
            div_next = divisor;
            cnt_next = 8'(DW);
            busy_next = 1'b1;
        end else if (busy_reg) begin
            shifted = {rem_reg, dq_reg[DW-1]};
            if (shifted >= {2'b00, div_reg}) begin
                shifted = shifted - {2'b00, div_reg};
                dq_next = {dq_reg[DW-2:0], 1'b1};
            end else begin
                dq_next = {dq_reg[DW-2:0], 1'b0};
            end
            rem_next = shifted[VW:0];
            cnt_next = cnt_reg - 8'h01;
            if (cnt_reg == 8'h01) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                qd = neg_reg ? DW'(-dq_next) : dq_next;
                q_next = qd[SSE_WORD_W-1:0];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dq_reg <= '0;
            rem_reg <= '0;
            div_reg <= '0;
            neg_reg <= 1'b0;
            cnt_reg <= 8'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            q_reg <= '0;
        end else begin
            dq_reg <= dq_next;
            rem_reg <= rem_next;
            div_reg <= div_next;
            neg_reg <= neg_next;
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            q_reg <= q_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
    assign quotient = q_reg;
endmodule

/* logic/sse_engine.sv */
// per-segment statistics engine: min, max, average, positions, timestamp
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - every segment yields one summary with average, minimum and maximum; the code drops one ending while a summary is pending, flagging rec_overrun
// RULE2 - summary also holds both extreme positions and the trigger timestamp
// RULE3 - summary leaves as a fixed 32-byte record, eight 32-bit words
// RULE4 - segment length below 32 samples is a configuration error
// RULE5 - segment length must be 32 plus a multiple of 16 samples
// RULE6 - standard mode length limited to 2G samples over active channels
// RULE7 - streaming mode length limited to 2G samples, any channel count
// RULE8 - after segment end, 40 plus pretrigger samples of re-arm ignore triggers
// RULE9 - timestamp is 64-bit clock counter cleared manually or at acquisition start
// RULE10 - pretrigger must be 16 to 8192 samples in steps of 16
// RULE11 - positions count from segment start, first occurrence of an extreme wins
// RULE12 - summary follows the last sample; accumulators restart each segment
module sse_engine
    import sse_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic acq_start,
    input wire logic acq_stop,
    input wire logic ts_clear,
    input wire logic cfg_fifo_mode,
    input wire logic [1:0] cfg_chan_log2,
    input wire logic [SSE_LEN_W-1:0] cfg_seg_len,
    input wire logic [SSE_PRE_W-1:0] cfg_pretrig,
    input wire logic smp_valid,
    input wire logic signed [SSE_SAMPLE_W-1:0] smp_data,
    input wire logic smp_trigger,
    output logic rec_valid,
    output logic [SSE_WORD_W-1:0] rec_data,
    output logic rec_last,
    input wire logic rec_ready,
    output logic armed,
    output logic cfg_error,
    output logic rec_overrun
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic cfg_ok(input logic [SSE_LEN_W-1:0] len,
                                    input logic [SSE_PRE_W-1:0] pre,
                                    input logic fifo,
                                    input logic [1:0] chl2);
        logic ok;
        ok = 1'b1;
        // RULE4 minimum length
        if (len < SSE_MIN_SEG_LEN)
            ok = 1'b0;
        // RULE5 length step
        if ((len % SSE_SEG_STEP) != '0)
            ok = 1'b0;
        // RULE6 RULE7 length ceiling per mode
        if (fifo ? (len > SSE_MAX_SEG_LEN) : (len > (SSE_MAX_SEG_LEN >> chl2)))
            ok = 1'b0;
        // RULE10 pretrigger range and step
        if (pre < SSE_PRE_MIN || pre > SSE_PRE_MAX || (pre % SSE_PRE_STEP) != '0)
            ok = 1'b0;
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    sse_seg_state_t seg_reg, seg_next;
    logic run_reg, run_next;
    logic cfg_err_reg, cfg_err_next;
    logic [SSE_TS_W-1:0] ts_reg, ts_next;
    logic [SSE_LEN_W-1:0] cnt_reg, cnt_next;
    logic [SSE_LEN_W-1:0] len_reg, len_next;
    logic signed [SSE_SUM_W-1:0] sum_reg, sum_next;
    logic signed [SSE_SAMPLE_W-1:0] min_reg, min_next, max_reg, max_next;
    logic [SSE_LEN_W-1:0] minpos_reg, minpos_next, maxpos_reg, maxpos_next;
    logic [SSE_TS_W-1:0] tscap_reg, tscap_next;
    logic [15:0] rearm_reg, rearm_next;
    logic seg_end;
    logic signed [SSE_SUM_W-1:0] sum_final;
    logic signed [SSE_SAMPLE_W-1:0] min_final, max_final;
    logic [SSE_LEN_W-1:0] minpos_final, maxpos_final;

    always_comb begin
        logic ok;
        ok = cfg_ok(cfg_seg_len, cfg_pretrig, cfg_fifo_mode, cfg_chan_log2);
        seg_next = seg_reg;
        run_next = run_reg;
        cfg_err_next = !ok;
        cnt_next = cnt_reg;
        len_next = len_reg;
        sum_next = sum_reg;
        min_next = min_reg;
        max_next = max_reg;
        minpos_next = minpos_reg;
        maxpos_next = maxpos_reg;
        tscap_next = tscap_reg;
        rearm_next = rearm_reg;
        seg_end = 1'b0;
        // RULE9 free-running stamp counter
        ts_next = (ts_clear || acq_start) ? '0 : ts_reg + 64'h1;
        if (acq_start && ok)
            run_next = 1'b1;
        if (acq_stop)
            run_next = 1'b0;
        // running sample folded into the accumulators
        sum_final = sum_reg + SSE_SUM_W'(smp_data);
        min_final = min_reg;
        max_final = max_reg;
        minpos_final = minpos_reg;
        maxpos_final = maxpos_reg;
        // RULE11 strict compare keeps the earliest extreme
        if (smp_data < min_reg) begin
            min_final = smp_data;
            minpos_final = cnt_reg;
        end
        if (smp_data > max_reg) begin
            max_final = smp_data;
            maxpos_final = cnt_reg;
        end
        case (seg_reg)
            SSE_SEG_IDLE: begin
                if (acq_start && ok && !acq_stop)
                    seg_next = SSE_SEG_ARMED;
            end
            SSE_SEG_ARMED: begin
                if (!run_reg) begin
                    seg_next = SSE_SEG_IDLE;
                end else if (smp_valid && smp_trigger) begin
                    // RULE12 fresh accumulators, trigger sample is index 0
                    sum_next = SSE_SUM_W'(smp_data);
                    min_next = smp_data;
                    max_next = smp_data;
                    minpos_next = '0;
                    maxpos_next = '0;
                    cnt_next = 32'h1;
                    len_next = cfg_seg_len;
                    // RULE2 stamp taken at the trigger
                    tscap_next = ts_reg;
                    seg_next = SSE_SEG_COLLECT;
                end
            end
            SSE_SEG_COLLECT: begin
                if (smp_valid) begin
                    sum_next = sum_final;
                    min_next = min_final;
                    max_next = max_final;
                    minpos_next = minpos_final;
                    maxpos_next = maxpos_final;
                    cnt_next = cnt_reg + 32'h1;
                    // RULE12 summary only after the last sample
                    if (cnt_reg + 32'h1 == len_reg) begin
                        seg_end = 1'b1;
                        // RULE8 re-arm holdoff length
                        rearm_next = SSE_REARM_BASE + 16'(cfg_pretrig);
                        seg_next = SSE_SEG_REARM;
                    end
                end
            end
            SSE_SEG_REARM: begin
                // RULE8 triggers here are dropped
                if (smp_valid)
                    rearm_next = rearm_reg - 16'h1;
                if (smp_valid && rearm_reg == 16'h1)
                    seg_next = run_reg ? SSE_SEG_ARMED : SSE_SEG_IDLE;
            end
            default: seg_next = SSE_SEG_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            seg_reg <= SSE_SEG_IDLE;
            run_reg <= 1'b0;
            cfg_err_reg <= 1'b0;
            ts_reg <= '0;
            cnt_reg <= '0;
            len_reg <= '0;
            sum_reg <= '0;
            min_reg <= '0;
            max_reg <= '0;
            minpos_reg <= '0;
            maxpos_reg <= '0;
            tscap_reg <= '0;
            rearm_reg <= 16'h0000;
        end else begin
            seg_reg <= seg_next;
            run_reg <= run_next;
            cfg_err_reg <= cfg_err_next;
            ts_reg <= ts_next;
            cnt_reg <= cnt_next;
            len_reg <= len_next;
            sum_reg <= sum_next;
            min_reg <= min_next;
            max_reg <= max_next;
            minpos_reg <= minpos_next;
            maxpos_reg <= maxpos_next;
            tscap_reg <= tscap_next;
            rearm_reg <= rearm_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // snapshot and record output; the divider runs during the re-arm
    // holdoff, before the next segment accumulates, so re-arm time hides its latency
    sse_out_state_t out_reg, out_next;
    logic signed [SSE_SAMPLE_W-1:0] smin_reg, smin_next, smax_reg, smax_next;
    logic [SSE_LEN_W-1:0] sminp_reg, sminp_next, smaxp_reg, smaxp_next;
    logic [SSE_LEN_W-1:0] slen_reg, slen_next;
    logic [SSE_TS_W-1:0] sts_reg, sts_next;
    logic [SSE_WORD_W-1:0] avg_reg, avg_next;
    logic [2:0] widx_reg, widx_next;
    logic [SSE_WORD_W-1:0] wdata_reg, wdata_next;
    logic ovr_reg, ovr_next;
    logic div_start, div_done;
    logic signed [SSE_WORD_W-1:0] div_q;

    function automatic logic [SSE_WORD_W-1:0] rec_word(
        input logic [2:0] idx, input logic [SSE_WORD_W-1:0] avg,
        input logic signed [SSE_SAMPLE_W-1:0] mn, input logic signed [SSE_SAMPLE_W-1:0] mx,
        input logic [SSE_LEN_W-1:0] mnp, input logic [SSE_LEN_W-1:0] mxp,
        input logic [SSE_TS_W-1:0] ts, input logic [SSE_LEN_W-1:0] len);
        logic [SSE_WORD_W-1:0] w;
        w = '0;
        // RULE3 fixed word layout
        case (idx)
            SSE_W_AVG: w = avg;
            SSE_W_MINMAX: w = {mx, mn};
            SSE_W_MINPOS: w = mnp;
            SSE_W_MAXPOS: w = mxp;
            SSE_W_TS_LO: w = ts[31:0];
            SSE_W_TS_HI: w = ts[63:32];
            SSE_W_LEN: w = len;
            default: w = '0;
        endcase
        return w;
    endfunction

    always_comb begin
        out_next = out_reg;
        smin_next = smin_reg;
        smax_next = smax_reg;
        sminp_next = sminp_reg;
        smaxp_next = smaxp_reg;
        slen_next = slen_reg;
        sts_next = sts_reg;
        avg_next = avg_reg;
        widx_next = widx_reg;
        wdata_next = wdata_reg;
        ovr_next = 1'b0;
        div_start = 1'b0;
        case (out_reg)
            SSE_OUT_IDLE: begin
                if (seg_end) begin
                    // RULE1 RULE2 latch the finished segment
                    smin_next = min_final;
                    smax_next = max_final;
                    sminp_next = minpos_final;
                    smaxp_next = maxpos_final;
                    slen_next = len_reg;
                    sts_next = tscap_reg;
                    div_start = 1'b1;
                    out_next = SSE_OUT_DIV;
                end
            end
            SSE_OUT_DIV: begin
                ovr_next = seg_end;
                if (div_done) begin
                    avg_next = div_q;
                    widx_next = SSE_W_AVG;
                    wdata_next = rec_word(SSE_W_AVG, div_q, smin_reg, smax_reg,
                                          sminp_reg, smaxp_reg, sts_reg, slen_reg);
                    out_next = SSE_OUT_SEND;
                end
            end
            SSE_OUT_SEND: begin
                // a stalled writer loses the next summary, flagged once
                ovr_next = seg_end;
                if (rec_ready) begin
                    widx_next = widx_reg + 3'h1;
                    wdata_next = rec_word(widx_reg + 3'h1, avg_reg, smin_reg, smax_reg,
                                          sminp_reg, smaxp_reg, sts_reg, slen_reg);
                    if (widx_reg == SSE_W_LAST)
                        out_next = SSE_OUT_IDLE;
                end
            end
            default: out_next = SSE_OUT_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_reg <= SSE_OUT_IDLE;
            smin_reg <= '0;
            smax_reg <= '0;
            sminp_reg <= '0;
            smaxp_reg <= '0;
            slen_reg <= '0;
            sts_reg <= '0;
            avg_reg <= '0;
            widx_reg <= 3'h0;
            wdata_reg <= '0;
            ovr_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            smin_reg <= smin_next;
            smax_reg <= smax_next;
            sminp_reg <= sminp_next;
            smaxp_reg <= smaxp_next;
            slen_reg <= slen_next;
            sts_reg <= sts_next;
            avg_reg <= avg_next;
            widx_reg <= widx_next;
            wdata_reg <= wdata_next;
            ovr_reg <= ovr_next;
        end
    end

    // RULE1 average is the sum over the segment length
    sse_divider #(
        .DW(SSE_SUM_W),
        .VW(SSE_LEN_W)
    ) u_div (
        .clock(clock),
        .rst(rst),
        .start(div_start),
        .dividend(sum_final),
        .divisor(len_reg),
        .busy(),
        .done(div_done),
        .quotient(div_q)
    );

    assign rec_valid = (out_reg == SSE_OUT_SEND);
    assign rec_data = wdata_reg;
    assign rec_last = (out_reg == SSE_OUT_SEND) && (widx_reg == SSE_W_LAST);
    assign armed = (seg_reg == SSE_SEG_ARMED);
    assign cfg_error = cfg_err_reg;
    assign rec_overrun = ovr_reg;
endmodule

/* logic/sse_pkg.sv */
// constants and types of the segment statistics engine
package sse_pkg;
    localparam int SSE_SAMPLE_W = 16;
    localparam int SSE_SUM_W = 48;
    localparam int SSE_LEN_W = 32;
    localparam int SSE_PRE_W = 14;
    localparam int SSE_TS_W = 64;
    localparam int SSE_WORD_W = 32;
    localparam int SSE_REC_BYTES = 32;
    localparam int SSE_REC_WORDS = SSE_REC_BYTES / (SSE_WORD_W / 8);
    localparam logic [SSE_LEN_W-1:0] SSE_MIN_SEG_LEN = 32'h20;
    localparam logic [SSE_LEN_W-1:0] SSE_SEG_STEP = 32'h10;
    localparam logic [SSE_LEN_W-1:0] SSE_MAX_SEG_LEN = 32'h8000_0000;
    localparam logic [SSE_PRE_W-1:0] SSE_PRE_MIN = 14'h10;
    localparam logic [SSE_PRE_W-1:0] SSE_PRE_MAX = 14'h2000;
    localparam logic [SSE_PRE_W-1:0] SSE_PRE_STEP = 14'h10;
    localparam logic [15:0] SSE_REARM_BASE = 16'h0028;
    // record word positions
    localparam logic [2:0] SSE_W_AVG = 3'h0;
    localparam logic [2:0] SSE_W_MINMAX = 3'h1;
    localparam logic [2:0] SSE_W_MINPOS = 3'h2;
    localparam logic [2:0] SSE_W_MAXPOS = 3'h3;
    localparam logic [2:0] SSE_W_TS_LO = 3'h4;
    localparam logic [2:0] SSE_W_TS_HI = 3'h5;
    localparam logic [2:0] SSE_W_LEN = 3'h6;
    localparam logic [2:0] SSE_W_LAST = 3'h7;

    typedef enum logic [1:0] {
        SSE_SEG_IDLE = 2'b00,
        SSE_SEG_ARMED = 2'b01,
        SSE_SEG_COLLECT = 2'b10,
        SSE_SEG_REARM = 2'b11
    } sse_seg_state_t;

    typedef enum logic [1:0] {
        SSE_OUT_IDLE = 2'b00,
        SSE_OUT_DIV = 2'b01,
        SSE_OUT_SEND = 2'b10
    } sse_out_state_t;
endpackage

/* verif/sse_engine_checker.sv */
// concurrent checks on the ports of the statistics engine
`timescale 1ns/1ps
module sse_engine_checker
    import sse_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic acq_start,
    input wire logic [SSE_LEN_W-1:0] cfg_seg_len,
    input wire logic [SSE_PRE_W-1:0] cfg_pretrig,
    input wire logic smp_valid,
    input wire logic smp_trigger,
    input wire logic rec_valid,
    input wire logic [SSE_WORD_W-1:0] rec_data,
    input wire logic rec_last,
    input wire logic rec_ready,
    input wire logic armed,
    input wire logic cfg_error,
    input wire logic rec_overrun
);
    logic on_reg, on_next, rearm_reg, rearm_next, seg_end;
    logic [31:0] cnt_reg, cnt_next, len_reg, len_next, rcnt_reg, rcnt_next, rearm_len;
    logic [7:0] gap_reg, gap_next;
    logic [2:0] w_reg, w_next;

    // shadow segment tracking, ends on the edge taking the last sample
    assign seg_end = on_reg && smp_valid && (cnt_reg == len_reg - 32'h1);
    assign rearm_len = 32'(SSE_REARM_BASE) + 32'(cfg_pretrig);
    always_comb begin
        on_next = (on_reg || (armed && smp_valid && smp_trigger)) && !seg_end;
        cnt_next = (armed && smp_valid) ? 32'h1 : cnt_reg + 32'(smp_valid);
        len_next = armed ? cfg_seg_len : len_reg;
        // restarting on acq_start avoids a stale count after a stop
        rearm_next = (rearm_reg || seg_end) && !armed && !acq_start;
        rcnt_next = seg_end ? 32'h0 : rcnt_reg + 32'(smp_valid);
        gap_next = seg_end ? 8'h00 : gap_reg + 8'(gap_reg != 8'hFF);
        w_next = (rec_valid && rec_ready) ? (rec_last ? 3'h0 : w_reg + 3'h1) : w_reg;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {on_reg, rearm_reg, cnt_reg, len_reg, rcnt_reg, w_reg} <= '0;
            gap_reg <= 8'hFF;
        end else begin
            {on_reg, rearm_reg, cnt_reg, len_reg} <= {on_next, rearm_next, cnt_next, len_next};
            {rcnt_reg, gap_reg, w_reg} <= {rcnt_next, gap_next, w_next};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_take;
        armed && smp_valid && smp_trigger;
    endsequence
    sequence s_rec_open;
        !rec_valid ##1 rec_valid;
    endsequence

    a_last_place: assert property (rec_valid |-> (rec_last == (w_reg == 3'h7)))
        else $error("last flag not on eighth word");
    a_word_hold: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data))
        else $error("record word changed while stalled");
    a_trig_disarms: assert property (s_take |=> !armed)
        else $error("still armed after trigger");
    a_rearm_exact: assert property ($rose(armed) && rearm_reg |-> rcnt_reg == rearm_len)
        else $error("re-arm length wrong");
    a_rearm_hold: assert property (rearm_reg && rcnt_reg + 32'h2 <= rearm_len |=> !armed)
        else $error("armed too early");
    a_sum_latency: assert property (s_rec_open |-> gap_reg >= 8'h31 && gap_reg <= 8'h33)
        else $error("summary not at its fixed latency");
    a_sum_follows: assert property (seg_end |-> ##[1:60] rec_valid)
        else $error("no summary after segment");
    a_short_seg: assert property (cfg_seg_len < SSE_MIN_SEG_LEN |=> cfg_error)
        else $error("short segment accepted");
    a_len_step: assert property (cfg_seg_len[3:0] != 4'h0 |=> cfg_error)
        else $error("length off step accepted");
    a_pre_range: assert property (cfg_pretrig < SSE_PRE_MIN || cfg_pretrig > SSE_PRE_MAX
        || cfg_pretrig[3:0] != 4'h0 |=> cfg_error) else $error("bad pretrigger accepted");
    a_overrun_once: assert property (rec_overrun |=> !rec_overrun)
        else $error("overrun longer than one cycle");
endmodule

bind sse_engine sse_engine_checker chk_u (.clock, .rst, .acq_start, .cfg_seg_len,
    .cfg_pretrig, .smp_valid, .smp_trigger, .rec_valid, .rec_data, .rec_last, .rec_ready,
    .armed, .cfg_error, .rec_overrun);

/* verif/sse_writer_model.sv */
// memory writer model taking record words with random stalls
`timescale 1ns/1ps
module sse_writer_model
    import sse_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic rec_valid,
    input wire logic [SSE_WORD_W-1:0] rec_data,
    input wire logic rec_last,
    output logic rec_ready,
    output logic [7:0] rec_cnt,
    output logic frame_bad
);
    logic [SSE_WORD_W-1:0] words [8];
    logic [2:0] idx;
    logic [31:0] rnd = 32'h1357_9BDF;
    logic ready_reg = 1'b0;

    assign rec_ready = ready_reg;
    // stall pattern moves only off the sampling edge
    always @(negedge clock) begin
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        ready_reg <= rnd[0] | rnd[1];
    end
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            idx <= 3'h0;
            rec_cnt <= 8'h00;
            frame_bad <= 1'b0;
        end else if (rec_valid && rec_ready) begin
            words[idx] <= rec_data;
            idx <= idx + 3'h1;
            if (rec_last) begin
                rec_cnt <= rec_cnt + 8'h01;
                frame_bad <= frame_bad | (idx != 3'h7);
            end
        end
    end
endmodule

/* verif/test_segment_statistics_engine.sv */
// self-checking bench of the segment statistics engine
`timescale 1ns/1ps
module test_segment_statistics_engine
    import sse_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic acq_start = 1'b0, acq_stop = 1'b0, ts_clear = 1'b0, cfg_fifo_mode = 1'b0;
    logic smp_valid = 1'b0, smp_trigger = 1'b0;
    logic [1:0] cfg_chan_log2 = 2'h0;
    logic [SSE_LEN_W-1:0] cfg_seg_len = 32'h20;
    logic [SSE_PRE_W-1:0] cfg_pretrig = 14'h10;
    logic signed [SSE_SAMPLE_W-1:0] smp_data = 16'h0;
    logic rec_valid, rec_last, rec_ready, armed, cfg_error, rec_overrun, frame_bad;
    logic [SSE_WORD_W-1:0] rec_data;
    logic [7:0] rec_cnt;
    logic [31:0] seed = 32'hA859_DEA0;
    logic [31:0] exp_w [8];
    int num_errors = 0, cmp_count = 0, cyc = 0, ovr = 0;
    int trig_cyc, clr_cyc;
    logic [31:0] t_len [12] = '{32'h1F, 32'h28, 32'h30, 32'h20, 32'h20, 32'h20, 32'h1000_0010,
        32'h1000_0010, 32'h8000_0000, 32'h8000_0010, 32'h4000_0000, 32'h4000_0010};
    logic [13:0] t_pre [12] = '{14'h10, 14'h10, 14'h10, 14'h8, 14'h2000, 14'h2010, 14'h10,
        14'h10, 14'h10, 14'h10, 14'h18, 14'h10};
    logic [2:0] t_mode [12] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h7, 3'h4, 3'h4,
        3'h1, 3'h1};

    always #25 clock = ~clock;

    sse_engine dut_u (.clock, .rst, .acq_start, .acq_stop, .ts_clear, .cfg_fifo_mode,
        .cfg_chan_log2, .cfg_seg_len, .cfg_pretrig, .smp_valid, .smp_data, .smp_trigger,
        .rec_valid, .rec_data, .rec_last, .rec_ready, .armed, .cfg_error, .rec_overrun);
    sse_writer_model wr_u (.clock, .rst, .rec_valid, .rec_data, .rec_last, .rec_ready,
        .rec_cnt, .frame_bad);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (rec_overrun === 1'b1) ovr <= ovr + 1;
        if (cyc == 3000) begin
            num_errors++;
            end_sim();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] want);
        cmp_count++;
        if (seen !== want) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
        end
    endtask

    // mode is {streaming, log2 of active channels}
    function automatic logic exp_err(logic [31:0] len, logic [13:0] pre, logic [2:0] mode);
        logic [31:0] lim;
        lim = mode[2] ? SSE_MAX_SEG_LEN : (SSE_MAX_SEG_LEN >> mode[1:0]);
        return len < SSE_MIN_SEG_LEN || len[3:0] != 4'h0 || len > lim || pre < SSE_PRE_MIN
            || pre > SSE_PRE_MAX || pre[3:0] != 4'h0;
    endfunction

    task automatic set_cfg(input logic [31:0] len, input logic [13:0] pre, input logic [2:0] m);
        @(negedge clock);
        cfg_seg_len = len;
        cfg_pretrig = pre;
        {cfg_fifo_mode, cfg_chan_log2} = m;
        repeat (2) @(negedge clock);
        chk(cfg_error, exp_err(len, pre, m));
    endtask

    task automatic pulse(input logic st);
        @(negedge clock);
        acq_start = st;
        acq_stop = !st;
        if (st) clr_cyc = cyc;
        @(negedge clock);
        acq_start = 1'b0;
        acq_stop = 1'b0;
    endtask

    // extremes forced at pmx/pmx+2 and pmn/last so ties hit the first occurrence
    task automatic run_seg(input int len, input int pmx, input int pmn, input logic clr);
        int n;
        longint sum;
        logic [31:0] r;
        logic signed [15:0] d, mx, mn;
        logic [7:0] cnt0;
        n = 0;
        sum = 0;
        cnt0 = rec_cnt;
        while (armed !== 1'b1 && n < 300) begin
            @(negedge clock);
            n++;
        end
        // optional manual clear, then a random idle gap so the stamp is not trivially zero
        if (clr) clr_cyc = cyc;
        ts_clear = clr;
        @(negedge clock);
        ts_clear = 1'b0;
        repeat (xs() % 16) @(negedge clock);
        for (int i = 0; i < len; i++) begin
            r = xs();
            d = {{4{r[11]}}, r[11:0]};
            if (i == pmx || i == pmx + 2) d = 16'h7FFF;
            if (i == pmn || i == len - 1) d = 16'h8000;
            if (i == 0 || d > mx) {mx, exp_w[3]} = {d, 32'(i)};
            if (i == 0 || d < mn) {mn, exp_w[2]} = {d, 32'(i)};
            sum += d;
            if (i == 0) trig_cyc = cyc;
            smp_valid = 1'b1;
            smp_data = d;
            smp_trigger = (i == 0) || r[20];
            @(negedge clock);
        end
        n = 0;
        // triggers keep coming during re-arm and must be ignored
        while (armed !== 1'b1 && n < 9000) begin
            r = xs();
            smp_trigger = r[0];
            smp_data = r[15:0];
            n++;
            @(negedge clock);
        end
        smp_valid = 1'b0;
        smp_trigger = 1'b0;
        chk(n, 64'(SSE_REARM_BASE) + 64'(cfg_pretrig));
        while (rec_cnt === cnt0 && n < 9300) begin
            @(negedge clock);
            n++;
        end
        exp_w[0] = 32'(sum / len);
        exp_w[1] = {mx, mn};
        exp_w[6] = len;
        exp_w[7] = 32'h0;
        for (int i = 0; i < 8; i++)
            if (i < 4 || i > 5) chk(wr_u.words[i], exp_w[i]);
        chk({wr_u.words[5], wr_u.words[4]}, 64'(trig_cyc - clr_cyc - 1));
    endtask

    initial begin
        logic [31:0] r;
        repeat (6) @(negedge clock);
        rst = 1'b0;
        set_cfg(32'h1F, 14'h10, 3'h0);
        pulse(1'b1);
        repeat (3) @(negedge clock);
        chk(armed, 1'b0);
        for (int i = 0; i < 12; i++) set_cfg(t_len[i], t_pre[i], t_mode[i]);
        for (int i = 0; i < 16; i++) begin
            r = xs();
            set_cfg(r & 32'h3F8, r[13:0] & 14'h7F8, r[31:29]);
        end
        set_cfg(32'h20, 14'h10, 3'h0);
        pulse(1'b1);
        run_seg(32, 0, 5, 1'b1);
        run_seg(32, 20, 1, 1'b1);
        pulse(1'b0);
        set_cfg(32'h30, 14'h30, 3'h6);
        pulse(1'b1);
        run_seg(48, 45, 0, 1'b0);
        chk(ovr, 0);
        chk(frame_bad, 1'b0);
        end_sim();
    end
endmodule
